// ==== scp_top.sv ====
// Function
// - one static mode pin picks pin control or register control; never changed live.
// - register mode takes single or double rate from setup bit 10.
// - register mode takes double-rate phase from bit 11; pin mode zero phase only.
// - register mode takes single-rate data edge from setup bit 8.
// - register mode takes output swing from setup bit 9, not the pin.
// - pin mode picks calibration delay by pin; register mode always short.
// - register mode sets full-scale range from bits 15..7 of register 3.
// - register mode applies offset from bits 15..7 of register 2; none in pin mode.
// - pin mode tunes sample phase itself; register mode uses fine and coarse.
// - register mode drives test pattern when pattern register bit 11 set.
// - register mode trim bypass bit 13 keeps the data clock running through calibration.
// - power-on reset loads the register-mode defaults.
// - frames are taken only in register mode; pins ignored otherwise.
// - registers are write only; nothing reads them back.
// - data sampled on each rising serial clock edge, at any slow rate.
// - 32-bit frames, msb first, opening with eleven zeros then a one.
// - then four address bits, then sixteen data bits for that register.
// - next frame may start on the 33rd clock without releasing select.
// - in pin mode the register contents have no effect.
`timescale 1ns/10ps
`default_nettype none

module scp_top
    import scp_pkg::*;
(
    // core clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // serial link
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic serial_input_line,
    // mode and feature pins
    input wire logic range_or_mode_select_pin,
    input wire logic range_or_mode_float,
    input wire logic edge_rate_pin,
    input wire logic edge_rate_float,
    input wire logic swing_pin,
    input wire logic cal_delay_pin,
    // calibration status from the converter core
    input wire logic cal_running,
    // effective controls to the converter
    output logic extended_mode,
    output logic ddr_mode,
    output logic ddr_phase_90,
    output logic sdr_rising_edge,
    output logic output_swing_std,
    output logic cal_delay_long,
    output logic fullscale_pin_high,
    output logic [8:0] fullscale_code,
    output logic offset_enable,
    output logic [8:0] offset_code,
    output logic auto_phase_enable,
    output logic [15:0] phase_fine,
    output logic [15:0] phase_coarse,
    output logic pattern_enable,
    output logic output_data_clock_enable,
    // frame observation
    output logic frame_written,
    output logic frame_rejected
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // one-hot select of the six implemented registers; zero if reserved
    function automatic logic [5:0] scp_decode(input logic [3:0] addr);
        logic [5:0] sel;
        sel = 6'h00;
        case (addr)
            SCP_ADDR_OUTPUT_SETUP: sel = 6'h01;
            SCP_ADDR_INPUT_OFFSET: sel = 6'h02;
            SCP_ADDR_FULLSCALE: sel = 6'h04;
            SCP_ADDR_PHASE_FINE: sel = 6'h08;
            SCP_ADDR_PHASE_COARSE: sel = 6'h10;
            SCP_ADDR_PATTERN: sel = 6'h20;
            default: sel = 6'h00;
        endcase
        return sel;
    endfunction : scp_decode

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [31:0] rx_word;
    logic rx_toggle;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic frame_event;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic mode_ext;
    logic [31:0] held_word;
    logic [5:0] held_sel;
    logic held_ok;
    scp_state_t state;
    scp_state_t next_state;
    logic [15:0] output_setup;
    logic [15:0] input_offset_trim;
    logic [15:0] fullscale_range_trim;
    logic [15:0] sample_phase_fine;
    logic [15:0] sample_phase_coarse;
    logic [15:0] pattern_control;

    // ----------------------------------------------------------------
    // serial link domain
    // ----------------------------------------------------------------
    scp_frame_rx u_rx (
        .sclk(sclk),
        .reset_n(reset_n),
        .serial_select_n(serial_select_n),
        .serial_input_line(serial_input_line),
        .frame_word(rx_word),
        .frame_toggle(rx_toggle)
    );

    // ----------------------------------------------------------------
    // crossings into mclk
    // ----------------------------------------------------------------
    // toggle synchroniser; the third stage only feeds the edge compare
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            tog_meta <= rx_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
        end
    end

    assign frame_event = tog_sync ^ tog_seen;

    // pins are asynchronous to mclk, so two stages each
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= {cal_delay_pin, swing_pin, edge_rate_float,
                         edge_rate_pin, range_or_mode_float,
                         range_or_mode_select_pin};
            pin_sync <= pin_meta;
        end
    end

    // a floating mode pin selects register control; treated as static
    assign mode_ext = pin_sync[1];

    // ----------------------------------------------------------------
    // commit sequencer
    // ----------------------------------------------------------------
    // word from the link is stable for 31 serial clocks after the toggle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SCP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            SCP_IDLE: begin
                if (frame_event) begin
                    next_state = SCP_DECODE;
                end
            end
            SCP_DECODE: begin
                next_state = SCP_COMMIT;
            end
            SCP_COMMIT: begin
                next_state = SCP_IDLE;
            end
            default: begin
                next_state = SCP_IDLE;
            end
        endcase
    end

    // capture then check header, address and mode in one pass
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            held_word <= 32'h00000000;
            held_sel <= 6'h00;
            held_ok <= 1'b0;
        end else if (state == SCP_IDLE && frame_event) begin
            held_word <= rx_word;
        end else if (state == SCP_DECODE) begin
            held_sel <= scp_decode(held_word[SCP_ADDR_MSB:SCP_ADDR_LSB]);
            held_ok <= mode_ext
                && held_word[SCP_HDR_MSB:SCP_HDR_LSB] == SCP_HEADER
                && scp_decode(held_word[SCP_ADDR_MSB:SCP_ADDR_LSB]) != 6'h00;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // write only: no read path exists anywhere in the block
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            output_setup <= SCP_RST_OUTPUT_SETUP;
            input_offset_trim <= SCP_RST_INPUT_OFFSET;
            fullscale_range_trim <= SCP_RST_FULLSCALE;
            sample_phase_fine <= SCP_RST_PHASE_FINE;
            sample_phase_coarse <= SCP_RST_PHASE_COARSE;
            pattern_control <= SCP_RST_PATTERN;
        end else if (state == SCP_COMMIT && held_ok) begin
            if (held_sel[0]) begin
                output_setup <= held_word[SCP_DATA_MSB:0];
            end
            if (held_sel[1]) begin
                input_offset_trim <= held_word[SCP_DATA_MSB:0];
            end
            if (held_sel[2]) begin
                fullscale_range_trim <= held_word[SCP_DATA_MSB:0];
            end
            if (held_sel[3]) begin
                sample_phase_fine <= held_word[SCP_DATA_MSB:0];
            end
            if (held_sel[4]) begin
                sample_phase_coarse <= held_word[SCP_DATA_MSB:0];
            end
            if (held_sel[5]) begin
                pattern_control <= held_word[SCP_DATA_MSB:0];
            end
        end
    end

    // one-cycle reports of each frame outcome
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            frame_written <= 1'b0;
            frame_rejected <= 1'b0;
        end else begin
            frame_written <= state == SCP_COMMIT && held_ok;
            frame_rejected <= state == SCP_COMMIT && !held_ok;
        end
    end

    // ----------------------------------------------------------------
    // output clocking controls
    // ----------------------------------------------------------------
    // pin mode: floating edge pin means double rate, else edge level
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            extended_mode <= 1'b0;
            ddr_mode <= 1'b1;
            ddr_phase_90 <= 1'b0;
            sdr_rising_edge <= 1'b0;
        end else if (mode_ext) begin
            extended_mode <= 1'b1;
            ddr_mode <= ~output_setup[SCP_RATE_MODE_BIT];
            ddr_phase_90 <= output_setup[SCP_DDR_PHASE_BIT];
            sdr_rising_edge <= output_setup[SCP_OUT_EDGE_BIT];
        end else begin
            extended_mode <= 1'b0;
            ddr_mode <= pin_sync[3];
            ddr_phase_90 <= 1'b0;
            sdr_rising_edge <= pin_sync[2];
        end
    end

    // swing and calibration delay
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            output_swing_std <= 1'b1;
            cal_delay_long <= 1'b0;
        end else if (mode_ext) begin
            output_swing_std <= output_setup[SCP_SWING_BIT];
            cal_delay_long <= 1'b0;
        end else begin
            output_swing_std <= pin_sync[4];
            cal_delay_long <= pin_sync[5];
        end
    end

    // ----------------------------------------------------------------
    // analog trims
    // ----------------------------------------------------------------
    // pin mode keeps codes at rest and gives range by the pin level
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fullscale_pin_high <= 1'b0;
            fullscale_code <= 9'h000;
            offset_enable <= 1'b0;
            offset_code <= 9'h000;
        end else if (mode_ext) begin
            fullscale_pin_high <= 1'b0;
            fullscale_code <= fullscale_range_trim[SCP_TRIM_MSB:SCP_TRIM_LSB];
            offset_enable <= 1'b1;
            offset_code <= input_offset_trim[SCP_TRIM_MSB:SCP_TRIM_LSB];
        end else begin
            fullscale_pin_high <= pin_sync[0];
            fullscale_code <= 9'h000;
            offset_enable <= 1'b0;
            offset_code <= 9'h000;
        end
    end

    // ----------------------------------------------------------------
    // sample phase and test pattern
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            auto_phase_enable <= 1'b1;
            phase_fine <= 16'h0000;
            phase_coarse <= 16'h0000;
            pattern_enable <= 1'b0;
        end else if (mode_ext) begin
            auto_phase_enable <= 1'b0;
            phase_fine <= sample_phase_fine;
            phase_coarse <= sample_phase_coarse;
            pattern_enable <= pattern_control[SCP_PATTERN_ENABLE_BIT];
        end else begin
            auto_phase_enable <= 1'b1;
            phase_fine <= 16'h0000;
            phase_coarse <= 16'h0000;
            pattern_enable <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // output data clock gating
    // ----------------------------------------------------------------
    // clock drops during calibration so the termination can be trimmed,
    // unless bypass asks to keep it; bypass exists in register mode only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            output_data_clock_enable <= 1'b0;
        end else begin
            output_data_clock_enable <= !cal_running
                || (mode_ext && output_setup[SCP_TRIM_BYPASS_BIT]);
        end
    end

endmodule : scp_top

`default_nettype wire

// ==== scp_pkg.sv ====
`default_nettype none

package scp_pkg;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam logic [4:0] SCP_LAST_BIT = 5'h1f;
    localparam logic [11:0] SCP_HEADER = 12'h001;
    localparam int SCP_HDR_MSB = 31;
    localparam int SCP_HDR_LSB = 20;
    localparam int SCP_ADDR_MSB = 19;
    localparam int SCP_ADDR_LSB = 16;
    localparam int SCP_DATA_MSB = 15;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [3:0] SCP_ADDR_OUTPUT_SETUP = 4'h1;
    localparam logic [3:0] SCP_ADDR_INPUT_OFFSET = 4'h2;
    localparam logic [3:0] SCP_ADDR_FULLSCALE = 4'h3;
    localparam logic [3:0] SCP_ADDR_PHASE_FINE = 4'hd;
    localparam logic [3:0] SCP_ADDR_PHASE_COARSE = 4'he;
    localparam logic [3:0] SCP_ADDR_PATTERN = 4'hf;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SCP_OUT_EDGE_BIT = 8;
    localparam int SCP_SWING_BIT = 9;
    localparam int SCP_RATE_MODE_BIT = 10;
    localparam int SCP_DDR_PHASE_BIT = 11;
    localparam int SCP_TRIM_BYPASS_BIT = 13;
    localparam int SCP_PATTERN_ENABLE_BIT = 11;
    localparam int SCP_TRIM_MSB = 15;
    localparam int SCP_TRIM_LSB = 7;

    // ----------------------------------------------------------------
    // power-on values
    // ----------------------------------------------------------------
    localparam logic [15:0] SCP_RST_OUTPUT_SETUP = 16'h92ff;
    localparam logic [15:0] SCP_RST_INPUT_OFFSET = 16'h007f;
    localparam logic [15:0] SCP_RST_FULLSCALE = 16'h807f;
    localparam logic [15:0] SCP_RST_PHASE_FINE = 16'h0000;
    localparam logic [15:0] SCP_RST_PHASE_COARSE = 16'h0000;
    localparam logic [15:0] SCP_RST_PATTERN = 16'h0000;

    // ----------------------------------------------------------------
    // commit sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SCP_IDLE = 3'b001,
        SCP_DECODE = 3'b010,
        SCP_COMMIT = 3'b100
    } scp_state_t;

endpackage : scp_pkg

`default_nettype wire

// ==== scp_frame_rx.sv ====
`timescale 1ns/10ps
`default_nettype none

module scp_frame_rx
    import scp_pkg::*;
(
    // link clock and reset
    input wire logic sclk,
    input wire logic reset_n,
    // serial pins
    input wire logic serial_select_n,
    input wire logic serial_input_line,
    // frame to the core domain
    output logic [31:0] frame_word,
    output logic frame_toggle
);

    logic [4:0] bit_count;
    logic [30:0] shift;

    // ----------------------------------------------------------------
    // bit counter
    // ----------------------------------------------------------------
    // released select clears the count at once, since sclk may stop
    always_ff @(posedge sclk or negedge reset_n or posedge serial_select_n) begin
        if (!reset_n) begin
            bit_count <= 5'h00;
        end else if (serial_select_n) begin
            bit_count <= 5'h00;
        end else begin
            bit_count <= bit_count + 5'h01;
        end
    end

    // msb first shift on the rising edge
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            shift <= 31'h00000000;
        end else if (!serial_select_n) begin
            shift <= {shift[29:0], serial_input_line};
        end
    end

    // ----------------------------------------------------------------
    // frame hand-off
    // ----------------------------------------------------------------
    // word holds for 31 more edges, long enough for the core to take it
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            frame_word <= 32'h00000000;
            frame_toggle <= 1'b0;
        end else if (!serial_select_n && bit_count == SCP_LAST_BIT) begin
            frame_word <= {shift, serial_input_line};
            frame_toggle <= ~frame_toggle;
        end
    end

endmodule : scp_frame_rx

`default_nettype wire

// ==== scp_top_sva.sv ====
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module scp_top_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // calibration status
    input wire logic cal_running,
    // controls
    input wire logic extended_mode,
    input wire logic ddr_phase_90,
    input wire logic cal_delay_long,
    input wire logic offset_enable,
    input wire logic [8:0] offset_code,
    input wire logic auto_phase_enable,
    input wire logic [15:0] phase_fine,
    input wire logic [15:0] phase_coarse,
    input wire logic pattern_enable,
    input wire logic output_data_clock_enable,
    // frame events
    input wire logic frame_written,
    input wire logic frame_rejected
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // a frame lasts 32 link clocks, so events are far apart
    sequence s_frame_event;
        frame_written || frame_rejected;
    endsequence
    sequence s_link_quiet;
        !(frame_written || frame_rejected) [*8];
    endsequence
    sequence s_cal_idle;
        !cal_running [*3];
    endsequence

    property p_pulse_excl;
        !(frame_written && frame_rejected);
    endproperty
    a_pulse_excl: assert property (p_pulse_excl) else $error("stored and dropped at once");
    property p_frame_gap;
        s_frame_event |=> s_link_quiet;
    endproperty
    a_frame_gap: assert property (p_frame_gap) else $error("frame events too close");
    property p_pin_refuse;
        !extended_mode |-> !frame_written;
    endproperty
    a_pin_refuse: assert property (p_pin_refuse) else $error("frame stored in pin mode");
    property p_short_cal;
        extended_mode |-> !cal_delay_long;
    endproperty
    a_short_cal: assert property (p_short_cal) else $error("long delay in register mode");
    property p_pin_inert;
        !extended_mode |-> !offset_enable && offset_code == 9'h000 && !pattern_enable
            && phase_fine == 16'h0000 && phase_coarse == 16'h0000;
    endproperty
    a_pin_inert: assert property (p_pin_inert) else $error("register value in pin mode");
    property p_auto_phase;
        auto_phase_enable == !extended_mode;
    endproperty
    a_auto_phase: assert property (p_auto_phase) else $error("phase tuning mode wrong");
    property p_pin_phase;
        !extended_mode |-> !ddr_phase_90;
    endproperty
    a_pin_phase: assert property (p_pin_phase) else $error("90 degree phase in pin mode");
    property p_clock_kept;
        s_cal_idle |-> output_data_clock_enable;
    endproperty
    a_clock_kept: assert property (p_clock_kept) else $error("data clock off while idle");
endmodule : scp_top_sva

bind scp_top scp_top_sva u_sva (.mclk, .reset_n, .cal_running, .extended_mode, .ddr_phase_90,
    .cal_delay_long, .offset_enable, .offset_code, .auto_phase_enable, .phase_fine,
    .phase_coarse, .pattern_enable, .output_data_clock_enable, .frame_written,
    .frame_rejected);

`default_nettype wire

// ==== scp_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module scp_host_model (
    // serial link toward the device
    output logic sclk,
    output logic serial_select_n,
    output logic serial_input_line
);
    // clock parked low and select idle outside frames
    initial begin
        sclk = 1'b0;
        serial_select_n = 1'b1;
        serial_input_line = 1'b1;
    end

    // frames back to back under one select; n below 32 cuts each short
    task automatic burst(input logic [31:0] q [$], input int n);
        #7;
        serial_select_n = 1'b0;
        foreach (q[f]) begin
            for (int i = 31; i > 31 - n; i--) begin
                serial_input_line = q[f][i];
                #16 sclk = 1'b1;
                #16 sclk = 1'b0;
            end
        end
        #16 serial_select_n = 1'b1;
        // released line shows the inverse, never a stale valid bit
        serial_input_line = ~serial_input_line;
        #40;
    endtask : burst
endmodule : scp_host_model

`default_nettype wire

// ==== serial_config_port_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

module serial_config_port_bench;
    logic mclk, reset_n, sclk, serial_select_n, serial_input_line;
    logic range_or_mode_select_pin, range_or_mode_float, edge_rate_pin, edge_rate_float;
    logic swing_pin, cal_delay_pin, cal_running;
    logic extended_mode, ddr_mode, ddr_phase_90, sdr_rising_edge, output_swing_std;
    logic cal_delay_long, fullscale_pin_high, offset_enable, auto_phase_enable;
    logic pattern_enable, output_data_clock_enable, frame_written, frame_rejected;
    logic [8:0] fullscale_code, offset_code;
    logic [15:0] phase_fine, phase_coarse;
    int fail_count = 0;
    int samples_checked = 0;
    int n_wr = 0;
    int n_rej = 0;
    int cycles = 0;
    bit ext;
    logic [15:0] regs [16];
    logic [31:0] q [$];

    scp_top u_dut (.mclk, .reset_n, .sclk, .serial_select_n, .serial_input_line,
        .range_or_mode_select_pin, .range_or_mode_float, .edge_rate_pin, .edge_rate_float,
        .swing_pin, .cal_delay_pin, .cal_running, .extended_mode, .ddr_mode, .ddr_phase_90,
        .sdr_rising_edge, .output_swing_std, .cal_delay_long, .fullscale_pin_high,
        .fullscale_code, .offset_enable, .offset_code, .auto_phase_enable, .phase_fine,
        .phase_coarse, .pattern_enable, .output_data_clock_enable, .frame_written,
        .frame_rejected);
    scp_host_model u_host (.sclk, .serial_select_n, .serial_input_line);

    // ----------------------------------------------------------------
    // clock, event counts and hang guard
    // ----------------------------------------------------------------
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        n_wr += frame_written;
        n_rej += frame_rejected;
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ----------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------
    task automatic load_defaults();
        regs = '{default: 16'h0000};
        regs[1] = 16'h92ff;
        regs[2] = 16'h007f;
        regs[3] = 16'h807f;
    endtask : load_defaults

    function automatic logic [31:0] frame(input logic [3:0] a, input logic [15:0] d);
        return {12'h001, a, d};
    endfunction : frame

    // pins count only in pin mode, registers only in register mode
    task automatic check_all();
        logic [15:0] s;
        s = regs[1];
        check("extended_mode", extended_mode, ext);
        check("ddr_mode", ddr_mode, ext ? !s[10] : edge_rate_float);
        check("ddr_phase_90", ddr_phase_90, ext & s[11]);
        check("sdr_rising_edge", sdr_rising_edge, ext ? s[8] : edge_rate_pin);
        check("output_swing_std", output_swing_std, ext ? s[9] : swing_pin);
        check("cal_delay_long", cal_delay_long, !ext & cal_delay_pin);
        check("fullscale_code", fullscale_code, ext ? regs[3][15:7] : 9'h000);
        check("offset_code", offset_code, ext ? regs[2][15:7] : 9'h000);
        check("offset_enable", offset_enable, ext);
        check("auto_phase_enable", auto_phase_enable, !ext);
        check("phase_fine", phase_fine, ext ? regs[13] : 16'h0000);
        check("phase_coarse", phase_coarse, ext ? regs[14] : 16'h0000);
        check("pattern_enable", pattern_enable, ext & regs[15][11]);
        check("clock_enable", output_data_clock_enable, !cal_running | (ext & s[13]));
        check("fullscale_pin_high", fullscale_pin_high, !ext & range_or_mode_select_pin);
    endtask : check_all

    task automatic rand_pins();
        repeat (6) begin
            @(negedge mclk);
            {range_or_mode_select_pin, edge_rate_pin, edge_rate_float} = 3'($urandom);
            {swing_pin, cal_delay_pin, cal_running} = 3'($urandom);
            repeat (4) @(negedge mclk);
            check_all();
        end
        cal_running = 1'b0;
    endtask : rand_pins

    task automatic write_all();
        logic [15:0] d;
        logic [3:0] addrs [6] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf};
        q = {};
        foreach (addrs[i]) begin
            d = 16'($urandom);
            if (addrs[i] == 4'h1) begin
                d[7:0] = 8'hff;
                d[15] = 1'b1;
                if (!d[10])
                    d[8] = 1'b0;
            end
            regs[addrs[i]] = d;
            q.push_back(frame(addrs[i], d));
        end
        u_host.burst(q, 32);
    endtask : write_all

    // bounded wait for the commit pulses, then settle
    task automatic wait_pulses(input int wr, input int rj);
        int t;
        t = 0;
        while ((n_wr != wr || n_rej != rj) && t < 200) begin
            @(negedge mclk);
            t++;
        end
        repeat (3) @(negedge mclk);
        check("frames_written", n_wr, wr);
        check("frames_rejected", n_rej, rj);
    endtask : wait_pulses

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        {range_or_mode_select_pin, edge_rate_pin, swing_pin, cal_delay_pin} = 4'h0;
        {range_or_mode_float, edge_rate_float, cal_running} = 3'b110;
        void'($urandom(32'hefcb712c));
        ext = 1'b1;
        load_defaults();
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        check_all();
        rand_pins();
        write_all();
        wait_pulses(6, 0);
        rand_pins();
        // broken header, then every reserved address
        q = {{12'h801, 4'h1, 16'h0000}};
        for (int a = 0; a < 13; a++)
            if (a == 0 || a > 3)
                q.push_back(frame(4'(a), 16'h1234));
        u_host.burst(q, 32);
        wait_pulses(6, 11);
        check_all();
        // select dropped mid-frame, then a clean frame with trim bypass
        q = {frame(4'hf, ~regs[15])};
        u_host.burst(q, 20);
        regs[1] = 16'hb2ff;
        q = {frame(4'h1, 16'hb2ff)};
        u_host.burst(q, 32);
        wait_pulses(7, 11);
        rand_pins();
        // second reset straight into pin mode
        @(negedge mclk);
        reset_n = 1'b0;
        range_or_mode_float = 1'b0;
        ext = 1'b0;
        load_defaults();
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        write_all();
        wait_pulses(7, 17);
        rand_pins();
        give_verdict();
    end
endmodule : serial_config_port_bench

`default_nettype wire
